// ### shared/flash_pin_pkg.sv
// Constants shared by the flash pin-control block.
// Assumes a single 125 MHz system clock; bus pins arrive asynchronously.
package flash_pin_pkg;
  // Pin vector layout after the pin synchroniser
  localparam int PIN_W       = 15;
  localparam int PIN_CLK     = 0;
  localparam int PIN_FRAME   = 1;
  localparam int PIN_LAD_LSB = 2;
  localparam int PIN_LRST    = 6;
  localparam int PIN_INIT    = 7;
  localparam int PIN_TOPLOCK = 8;
  localparam int PIN_BULK    = 9;
  localparam int PIN_ID_LSB  = 10;
  localparam int PIN_IFSEL   = 14;
  // Bus nibble codes
  localparam logic [3:0] START_LPC   = 4'h0;
  localparam logic [3:0] START_HUBRD = 4'hD;
  localparam logic [3:0] START_HUBWR = 4'hE;
  localparam logic [3:0] CYC_MEMRD   = 4'h4;
  localparam logic [3:0] CYC_MEMWR   = 4'h6;
  localparam logic [3:0] NIB_TAR     = 4'hF;
  localparam logic [3:0] NIB_SYNC_OK = 4'h0;
  localparam logic [3:0] LPC_ADDR_N  = 4'h8;
  localparam logic [3:0] HUB_ADDR_N  = 4'h7;
  localparam logic [3:0] DATA_N      = 4'h2;
  localparam logic [3:0] CNT_LAST    = 4'h1;
  // Identity field inside an LPC memory address
  localparam int LPC_ID_LSB = 22;
  // Array geometry
  localparam int ARR_AW = 19;
  localparam int SECT_N = 11;
  localparam int ROW_W  = 6;
  localparam logic [3:0] TOP32_TAG  = 4'hF;
  localparam logic [2:0] TOP64_TAG  = 3'h7;
  localparam logic [3:0] SECT_TOP32 = 4'hA;
  localparam logic [3:0] SECT_8K_HI = 4'h9;
  localparam logic [3:0] SECT_8K_LO = 4'h8;
  localparam logic [3:0] SECT_16K   = 4'h7;
  // Register map (byte addresses)
  localparam logic [7:0]  REG_LOCK   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [10:0] LOCK_RST   = 11'h000;
  // Bus cycle states, Gray-coded along the usual path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_HDR  = 4'h1,
    S_ADDR = 4'h3,
    S_SIZE = 4'h2,
    S_WDAT = 4'h6,
    S_TAR1 = 4'h7,
    S_TAR2 = 4'h5,
    S_SYNC = 4'h4,
    S_RDLO = 4'hC,
    S_RDHI = 4'hD,
    S_TAR3 = 4'hF,
    S_SKIP = 4'hE
  } bus_state_t;
endpackage

// ### verilog/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_i; output changes once stages 2 and 3 agree.
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Per bit: follow stage 3 only where stages 2 and 3 agree
    st_nxt.q  = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;
endmodule

// ### verilog/sector_guard.sv
// Program/erase permission from hardware protect pins and sector lock bits.
// Assumes all inputs are stable in clk_i domain; purely combinational.
`timescale 1ns/10ps
module sector_guard (
  input  wire logic                                hub_i,
  input  wire logic                                top_lock_n_i,
  input  wire logic                                bulk_protect_n_i,
  input  wire logic [flash_pin_pkg::SECT_N-1:0]    lock_i,
  input  wire logic [flash_pin_pkg::ARR_AW-1:0]    addr_i,
  input  wire logic                                erase_i,
  input  wire logic                                uniform_i,
  output logic                                     allow_o
);
  import flash_pin_pkg::*;

  function automatic logic [3:0] sector_of(input logic [ARR_AW-1:0] a);
    if (a[18:16] != TOP64_TAG) begin
      sector_of = {1'b0, a[18:16]};
    end else if (a[15]) begin
      sector_of = SECT_TOP32;
    end else if (a[14]) begin
      sector_of = a[13] ? SECT_8K_HI : SECT_8K_LO;
    end else begin
      sector_of = SECT_16K;
    end
  endfunction

  logic top32;
  logic top64;
  logic uni;
  logic top_rgn;
  logic hw_lock;
  logic reg_lock;

  always_comb begin
    top32   = addr_i[18:15] == TOP32_TAG;
    top64   = addr_i[18:16] == TOP64_TAG;
    uni     = erase_i && uniform_i;
    top_rgn = hub_i ? top64 : (top32 || (uni && top64));
    // Pins only add protection; lock bits keep applying either way
    hw_lock = top_rgn ? !top_lock_n_i : !bulk_protect_n_i;
    if (uni) begin
      reg_lock = top64 ? |lock_i[SECT_N-1:SECT_16K] : lock_i[addr_i[18:16]];
    end else begin
      reg_lock = lock_i[sector_of(addr_i)];
    end
    allow_o = !(hw_lock || reg_lock);
  end
endmodule

// ### verilog/flash_pin_ctrl.sv
// Pin-level control of a boot flash on a low-pin-count bus, with Wishbone registers.
// Assumes the array answers arr_rdata_i within two clocks of arr_rd_o; one clk_i domain.
// Functional notes
// - Frame low marks a cycle start; device decodes a new cycle from it.
// - Frame low mid-cycle aborts; device drops the cycle and releases the lines.
// - Shared nibble lines are driven by each party only in its own phases.
// - Interface reset low blocks writes, resets automation, floats the nibble lines.
// - Leaving reset, the device is in array-read mode.
// - Initialise input low acts exactly like the interface reset; here only outside programming mode, where init is output enable.
// - Top lock low refuses program/erase to top region, despite lock registers.
// - Top lock low in LPC mode refuses uniform erase of top 64K.
// - Top lock high lifts pin protection; lock registers still apply.
// - Top lock pin never changes lock register contents.
// - Bulk protect governs other sectors; high lifts pin protection only.
// - Bulk protect pin never changes lock register contents.
// - Bus identity comes from the four straps; boot device straps zero.
// - An unconnected strap reads as zero via its pull-down.
// - All interface logic is timed by the external bus clock; here clk_i times it and the bus clock is sampled as a pin.
// - Programming mode reuses clock, frame, init, data, protect and strap pins.
// - Interface select chooses mode; sampled out of reset, fixed afterward.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module flash_pin_ctrl (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire logic                              bus_clk_i,
  input  wire logic                              frame_n_i,
  input  wire logic [3:0]                        lad_i,
  output logic      [3:0]                        lad_o,
  output logic                                   lad_oe_o,
  input  wire logic                              lreset_n_i,
  input  wire logic                              init_n_i,
  input  wire logic                              top_lock_n_i,
  input  wire logic                              bulk_protect_n_i,
  input  wire logic [3:0]                        strap_select_i,
  input  wire logic                              interface_select_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  input  wire logic                              op_req_i,
  input  wire logic                              op_erase_i,
  input  wire logic                              op_uniform_i,
  input  wire logic [flash_pin_pkg::ARR_AW-1:0]  op_addr_i,
  output logic                                   op_grant_o,
  output logic                                   op_deny_o,
  output logic      [flash_pin_pkg::ARR_AW-1:0]  arr_addr_o,
  output logic      [7:0]                        arr_wdata_o,
  output logic                                   arr_wr_o,
  output logic                                   arr_rd_o,
  input  wire logic [7:0]                        arr_rdata_i,
  output logic                                   cui_rst_o,
  output logic                                   mux_mode_o
);
  import flash_pin_pkg::*;

  typedef struct packed {
    bus_state_t           state;
    logic                 hub;
    logic                 wr;
    logic                 match;
    logic [3:0]           cnt;
    logic [31:0]          addr;
    logic [7:0]           wdata;
    logic                 clk_d;
    logic                 we_d;
    logic [2*ROW_W-1:0]   mux_addr;
    logic                 mux;
    logic                 boot;
    logic                 in_rst;
    logic [SECT_N-1:0]    lock;
    logic                 wb_ack;
    logic [31:0]          wb_dat;
    logic                 lad_oe;
    logic [3:0]           lad;
    logic                 arr_wr;
    logic                 arr_rd;
    logic [7:0]           arr_wd;
    logic [ARR_AW-1:0]    arr_addr;
    logic                 op_grant;
    logic                 op_deny;
    logic                 cui_rst;
  } ctrl_t;

  // Write-enable history starts at the idle level so no false strobe follows reset
  localparam ctrl_t CTRL_RST = '{state: S_IDLE, lock: LOCK_RST, in_rst: 1'b1,
                                 cui_rst: 1'b1, we_d: 1'b1, default: '0};

  ctrl_t                st_r;
  ctrl_t                st_nxt;
  logic [PIN_W-1:0]     pin_raw;
  logic [PIN_W-1:0]     pin_q;
  logic                 p_clk;
  logic                 p_frame_n;
  logic [3:0]           p_lad;
  logic [3:0]           p_strap;
  logic                 rise;
  logic                 fall;
  logic                 in_rst_now;
  logic                 wb_req;
  logic                 lock_wr;
  logic                 allow;
  logic [31:0]          addr_sh;

  assign pin_raw = {interface_select_i, strap_select_i, bulk_protect_n_i, top_lock_n_i,
                    init_n_i, lreset_n_i, lad_i, frame_n_i, bus_clk_i};

  // Pins are asynchronous to clk_i, so every one is filtered before use
  pin_sync3 #(.W(PIN_W)) pin_sync3_i (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pin_raw),
    .q_o   (pin_q)
  );

  sector_guard sector_guard_i (
    .hub_i            (st_r.hub),
    .top_lock_n_i     (pin_q[PIN_TOPLOCK]),
    .bulk_protect_n_i (pin_q[PIN_BULK]),
    .lock_i           (st_r.lock),
    .addr_i           (op_addr_i),
    .erase_i          (op_erase_i),
    .uniform_i        (op_uniform_i),
    .allow_o          (allow)
  );

  assign p_clk     = pin_q[PIN_CLK];
  assign p_frame_n = pin_q[PIN_FRAME];
  assign p_lad     = pin_q[PIN_LAD_LSB +: 4];
  // A floating strap arrives as zero through its pad pull-down
  assign p_strap   = pin_q[PIN_ID_LSB +: 4];
  // Bus cycles step only on the bus clock's rising edge, seen through the filter; programming mode also uses the fall
  assign rise      = p_clk && !st_r.clk_d;
  assign fall      = !p_clk && st_r.clk_d;
  // Init doubles as output enable in programming mode, so it resets only on the bus
  assign in_rst_now = !pin_q[PIN_LRST] || (!st_r.mux && !pin_q[PIN_INIT]);
  assign wb_req    = wb_cyc_i && wb_stb_i && !st_r.wb_ack;
  assign lock_wr   = wb_req && wb_we_i && (wb_adr_i == REG_LOCK);
  assign addr_sh   = {st_r.addr[27:0], p_lad};

  always_comb begin
    st_nxt          = st_r;
    st_nxt.clk_d    = p_clk;
    st_nxt.we_d     = p_frame_n;
    st_nxt.arr_wr   = 1'b0;
    st_nxt.arr_rd   = 1'b0;
    st_nxt.op_grant = 1'b0;
    st_nxt.op_deny  = 1'b0;
    st_nxt.wb_ack   = wb_req;
    st_nxt.in_rst   = in_rst_now;
    st_nxt.cui_rst  = in_rst_now;
    st_nxt.boot     = 1'b1;
    if (in_rst_now || !st_r.boot) begin
      st_nxt.mux = pin_q[PIN_IFSEL];
    end

    // Register bus; only software touches the lock bits
    if (lock_wr) begin
      if (wb_sel_i[0]) begin
        st_nxt.lock[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        st_nxt.lock[SECT_N-1:8] = wb_dat_i[SECT_N-1:8];
      end
    end
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_LOCK:   st_nxt.wb_dat = 32'({st_r.lock});
        REG_STATUS: st_nxt.wb_dat = 32'({st_r.state, p_strap, st_r.hub, st_r.mux,
                                        pin_q[PIN_BULK], pin_q[PIN_TOPLOCK], st_r.in_rst});
        default:    st_nxt.wb_dat = 32'h0000_0000;
      endcase
    end

    // Program/erase permission from the automation
    if (op_req_i) begin
      st_nxt.op_grant = allow && !in_rst_now;
      st_nxt.op_deny  = !(allow && !in_rst_now);
    end

    if (in_rst_now) begin
      st_nxt.state  = S_IDLE;
      st_nxt.lad_oe = 1'b0;
    end else if (st_r.mux) begin
      // Clock pin is row/column strobe, frame is write enable, init is output enable
      if (fall) begin
        st_nxt.mux_addr[ROW_W-1:0] = {pin_q[PIN_BULK], pin_q[PIN_TOPLOCK], p_strap};
      end
      if (rise) begin
        st_nxt.mux_addr[2*ROW_W-1:ROW_W] = {pin_q[PIN_BULK], pin_q[PIN_TOPLOCK], p_strap};
      end
      if (p_frame_n && !st_r.we_d) begin
        st_nxt.arr_wr   = 1'b1;
        st_nxt.arr_addr = ARR_AW'(st_r.mux_addr);
        st_nxt.arr_wd   = {4'h0, p_lad};
      end
      st_nxt.lad_oe = !pin_q[PIN_INIT];
      st_nxt.lad    = arr_rdata_i[3:0];
    end else if (rise) begin
      if (!p_frame_n) begin
        // Frame low both starts and aborts; the last nibble under frame is the start
        st_nxt.lad_oe = 1'b0;
        st_nxt.hub    = p_lad != START_LPC;
        st_nxt.wr     = p_lad == START_HUBWR;
        st_nxt.state  = (p_lad == START_LPC || p_lad == START_HUBRD ||
                         p_lad == START_HUBWR) ? S_HDR : S_SKIP;
      end else begin
        unique case (st_r.state)
          S_IDLE, S_SKIP: st_nxt.state = st_r.state;
          S_HDR: begin
            if (st_r.hub) begin
              st_nxt.match = p_lad == p_strap;
              st_nxt.cnt   = HUB_ADDR_N;
              st_nxt.state = S_ADDR;
            end else if (p_lad == CYC_MEMRD || p_lad == CYC_MEMWR) begin
              st_nxt.wr    = p_lad == CYC_MEMWR;
              st_nxt.cnt   = LPC_ADDR_N;
              st_nxt.state = S_ADDR;
            end else begin
              st_nxt.state = S_SKIP;
            end
          end
          S_ADDR: begin
            st_nxt.addr = addr_sh;
            st_nxt.cnt  = st_r.cnt - CNT_LAST;
            if (st_r.cnt == CNT_LAST) begin
              if (!st_r.hub) begin
                st_nxt.match = addr_sh[LPC_ID_LSB +: 4] == p_strap;
              end
              st_nxt.arr_addr = addr_sh[ARR_AW-1:0];
              st_nxt.arr_rd   = !st_r.wr;
              st_nxt.cnt      = DATA_N;
              st_nxt.state    = st_r.hub ? S_SIZE : (st_r.wr ? S_WDAT : S_TAR1);
            end
          end
          S_SIZE: st_nxt.state = st_r.wr ? S_WDAT : S_TAR1;
          S_WDAT: begin
            st_nxt.wdata = {p_lad, st_r.wdata[7:4]};
            st_nxt.cnt   = st_r.cnt - CNT_LAST;
            if (st_r.cnt == CNT_LAST) begin
              st_nxt.state = S_TAR1;
            end
          end
          S_TAR1: st_nxt.state = S_TAR2;
          S_TAR2: begin
            if (!st_r.match) begin
              st_nxt.state = S_SKIP;
            end else begin
              st_nxt.lad_oe = 1'b1;
              st_nxt.lad    = NIB_SYNC_OK;
              st_nxt.state  = S_SYNC;
              st_nxt.arr_wr = st_r.wr;
              st_nxt.arr_wd = st_r.wdata;
            end
          end
          S_SYNC: begin
            st_nxt.lad   = st_r.wr ? NIB_TAR : arr_rdata_i[3:0];
            st_nxt.state = st_r.wr ? S_TAR3 : S_RDLO;
          end
          S_RDLO: begin
            st_nxt.lad   = arr_rdata_i[7:4];
            st_nxt.state = S_RDHI;
          end
          S_RDHI: begin
            st_nxt.lad   = NIB_TAR;
            st_nxt.state = S_TAR3;
          end
          S_TAR3: begin
            st_nxt.lad_oe = 1'b0;
            st_nxt.state  = S_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= CTRL_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign lad_o       = st_r.lad;
  assign lad_oe_o    = st_r.lad_oe;
  assign wb_dat_o    = st_r.wb_dat;
  assign wb_ack_o    = st_r.wb_ack;
  assign op_grant_o  = st_r.op_grant;
  assign op_deny_o   = st_r.op_deny;
  assign arr_addr_o  = st_r.arr_addr;
  assign arr_wdata_o = st_r.arr_wd;
  assign arr_wr_o    = st_r.arr_wr;
  assign arr_rd_o    = st_r.arr_rd;
  assign cui_rst_o   = st_r.cui_rst;
  assign mux_mode_o  = st_r.mux;

  frame_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st_r.mux && !in_rst_now && rise && !p_frame_n |=> st_r.state inside {S_HDR, S_SKIP})
    else $error("frame start not decoded");
  abort_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st_r.mux && rise && !p_frame_n |=> !lad_oe_o)
    else $error("lines held after abort");
  drive_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lad_oe_o && !st_r.mux |-> st_r.state inside {S_SYNC, S_RDLO, S_RDHI, S_TAR3})
    else $error("lines driven outside device phase");
  reset_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pin_q[PIN_LRST] |=> !lad_oe_o && !arr_wr_o && cui_rst_o && !op_grant_o)
    else $error("reset did not quiet the device");
  init_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st_r.mux && !pin_q[PIN_INIT] |=> cui_rst_o && st_r.state == S_IDLE)
    else $error("init did not act as reset");
  top_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op_req_i && !pin_q[PIN_TOPLOCK] && !st_r.hub && op_addr_i[18:15] == TOP32_TAG
    |=> op_deny_o && !op_grant_o)
    else $error("top boot sector not protected");
  uniform_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op_req_i && op_erase_i && op_uniform_i && !st_r.hub && !pin_q[PIN_TOPLOCK]
    && op_addr_i[18:16] == TOP64_TAG |=> op_deny_o)
    else $error("uniform erase of top region allowed");
  reg_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op_req_i && pin_q[PIN_TOPLOCK] && st_r.lock[SECT_TOP32] && !op_erase_i
    && op_addr_i[18:15] == TOP32_TAG |=> op_deny_o)
    else $error("lock bit ignored with top lock high");
  bulk_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op_req_i && !in_rst_now && pin_q[PIN_BULK] && !op_erase_i
    && op_addr_i[18:16] != TOP64_TAG && !st_r.lock[op_addr_i[18:16]] |=> op_grant_o)
    else $error("open sector refused");
  lock_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !lock_wr |=> $stable(st_r.lock))
    else $error("lock bits changed without a write");
  id_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.state == S_SKIP && !st_r.mux |-> !lad_oe_o)
    else $error("drove lines for a foreign cycle");
  mode_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r.boot && !in_rst_now |=> $stable(st_r.mux))
    else $error("interface mode changed in operation");
  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");

  hub_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r.hub && st_r.state == S_RDHI);
  lpc_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !st_r.hub && arr_wr_o && !st_r.mux);
  op_deny_c: cover property (@(posedge clk_i) disable iff (rst_i) op_deny_o);
  mux_write_c: cover property (@(posedge clk_i) disable iff (rst_i) st_r.mux && arr_wr_o);
endmodule

// ### sim/lpc_host_model.sv
// Behavioural host chipset on the low-pin-count bus: bus clock, frame and nibble lines.
// Assumes the bench resolves the shared nibble wire from both enables.
`timescale 1ns/10ps
module lpc_host_model (
  output logic       bus_clk_o,
  output logic       frame_n_o,
  output logic [3:0] lad_o,
  output logic       lad_oe_o,
  input  wire logic  dev_oe_i,
  input  wire logic [3:0] lad_i
);
  // Slowed from 33 MHz so the pin filter sees each edge; free running like a PCI clock
  initial bus_clk_o = 1'h0;
  always #32 bus_clk_o = ~bus_clk_o;
  initial begin
    frame_n_o = 1'h1;
    lad_o = 4'h0;
    lad_oe_o = 1'h0;
  end
  // Host changes lines mid-period, well clear of the edge the device samples
  task automatic put(input logic f, input logic [3:0] n);
    @(negedge bus_clk_o);
    frame_n_o <= f;
    lad_o <= n;
    lad_oe_o <= 1'h1;
  endtask
  // n nibbles follow the start nibble; m nibbles come back after the turnaround
  task automatic xfer(input logic [3:0] s, input logic [43:0] a, input int n, input int m,
                      output logic [19:0] res);
    res = '0;
    put(1'h0, s);
    for (int i = n - 1; i >= 0; i--) put(1'h1, a[i*4 +: 4]);
    put(1'h1, 4'hF);
    @(negedge bus_clk_o);
    lad_oe_o <= 1'h0;
    // The device sees the second turnaround edge only through its pin filter
    @(posedge bus_clk_o);
    for (int i = 0; i < m; i++) begin
      @(posedge bus_clk_o);
      res[i*5 +: 5] = {dev_oe_i, lad_i};
    end
    @(posedge bus_clk_o);
  endtask
endmodule

// ### sim/lpc_flash_pin_control_bench.sv
// Bench for the flash pin block: registers, write permission, bus reads, pin resets.
// Assumes lpc_host_model as bus partner; array data is address low byte xor 5A.
`timescale 1ns/10ps
module lpc_flash_pin_control_bench;
  import flash_pin_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, interface_select_i = 1'h0;
  logic lreset_n_i = 1'h1, init_n_i = 1'h1, top_lock_n_i = 1'h1, bulk_protect_n_i = 1'h1;
  logic [3:0] strap_select_i = 4'h0, wb_sel_i = 4'hF, lad_i, lad_o, h_lad;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, arr_rdata_i, arr_wdata_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic op_req_i = 1'h0, op_erase_i = 1'h0, op_uniform_i = 1'h0, op_grant_o, op_deny_o;
  logic [ARR_AW-1:0] op_addr_i = '0, arr_addr_o;
  logic bus_clk_i, frame_n_i, lad_oe_o, h_oe, cui_rst_o, arr_wr_o, arr_rd_o, mux_mode_o;
  int error_cnt = 0, num_checks = 0, rd_cnt = 0, wr_cnt = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (arr_rd_o === 1'h1) rd_cnt++;
    if (arr_wr_o === 1'h1) wr_cnt++;
  end
  // A released wire shows the inverse of the host value, never a stale copy
  assign lad_i = lad_oe_o ? lad_o : (h_oe ? h_lad : ~h_lad);
  assign arr_rdata_i = arr_addr_o[7:0] ^ 8'h5A;
  flash_pin_ctrl flash_pin_ctrl_i (.clk_i, .rst_i, .ce_i, .bus_clk_i, .frame_n_i, .lad_i,
    .lad_o, .lad_oe_o, .lreset_n_i, .init_n_i, .top_lock_n_i, .bulk_protect_n_i,
    .strap_select_i, .interface_select_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .op_req_i, .op_erase_i, .op_uniform_i,
    .op_addr_i, .op_grant_o, .op_deny_o, .arr_addr_o, .arr_wdata_o, .arr_wr_o,
    .arr_rd_o, .arr_rdata_i, .cui_rst_o, .mux_mode_o);
  lpc_host_model host_i (.bus_clk_o(bus_clk_i), .frame_n_o(frame_n_i), .lad_o(h_lad),
    .lad_oe_o(h_oe), .dev_oe_i(lad_oe_o), .lad_i(lad_i));
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic op(input logic [ARR_AW-1:0] a, input logic er, input logic un, input logic ok);
    @(posedge clk_i);
    op_req_i <= 1'h1;
    op_addr_i <= a;
    op_erase_i <= er;
    op_uniform_i <= un;
    @(posedge clk_i);
    op_req_i <= 1'h0;
    @(posedge clk_i);
    chk({op_grant_o, op_deny_o}, {ok, !ok});
  endtask
  // Lock is written before the pins move, then read back to prove pins leave it alone
  task automatic perm(input logic tl, input logic bp, input logic [10:0] lk,
                      input logic [ARR_AW-1:0] a, input logic er, input logic un, input logic ok);
    logic [31:0] q;
    wb(1'h1, REG_LOCK, {21'h0, lk}, q);
    top_lock_n_i <= tl;
    bulk_protect_n_i <= bp;
    repeat (8) @(posedge clk_i);
    wb(1'h0, REG_LOCK, 32'h0, q);
    chk(q, {21'h0, lk});
    op(a, er, un, ok);
  endtask
  task automatic rd(input logic [3:0] s, input logic [35:0] a, input logic hit);
    logic [19:0] r;
    logic [7:0] d;
    // Hub cycles end in a size nibble, so their low address byte sits one nibble up
    d = (s == START_LPC ? a[7:0] : a[11:4]) ^ 8'h5A;
    host_i.xfer(s, {8'h00, a}, 9, 4, r);
    if (hit) chk(r, {1'h1, 4'hF, 1'h1, d[7:4], 1'h1, d[3:0], 1'h1, NIB_SYNC_OK});
    else chk({r[19], r[14], r[9], r[4]}, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [19:0] r;
    host_i.xfer(START_LPC, {CYC_MEMWR, a, d[3:0], d[7:4]}, 11, 2, r);
    chk(r[9:0], {1'h1, NIB_TAR, 1'h1, NIB_SYNC_OK});
    chk({arr_addr_o, arr_wdata_o}, {a[ARR_AW-1:0], d});
  endtask
  task automatic pin_reset(input logic use_init);
    if (use_init) init_n_i <= 1'h0;
    else lreset_n_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    chk({cui_rst_o, lad_oe_o}, 32'h2);
    op(19'h1_0000, 1'h0, 1'h0, 1'h0);
    init_n_i <= 1'h1;
    lreset_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk(cui_rst_o, 32'h0);
    rd(START_LPC, {CYC_MEMRD, 32'h0000_0077}, 1'h1);
  endtask
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    wb(1'h1, 8'h08, 32'hFFFF_FFFF, q);
    wb(1'h0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    perm(1'h0, 1'h1, 11'h000, 19'h7_8000, 1'h0, 1'h0, 1'h0);
    perm(1'h0, 1'h1, 11'h000, 19'h7_4000, 1'h0, 1'h0, 1'h1);
    perm(1'h0, 1'h1, 11'h000, 19'h7_0000, 1'h1, 1'h1, 1'h0);
    perm(1'h1, 1'h1, 11'h000, 19'h7_8000, 1'h0, 1'h0, 1'h1);
    perm(1'h1, 1'h1, 11'h400, 19'h7_8000, 1'h0, 1'h0, 1'h0);
    perm(1'h1, 1'h0, 11'h000, 19'h0_0000, 1'h0, 1'h0, 1'h0);
    perm(1'h1, 1'h1, 11'h001, 19'h0_0000, 1'h0, 1'h0, 1'h0);
    perm(1'h1, 1'h1, 11'h001, 19'h1_0000, 1'h0, 1'h0, 1'h1);
    rd(START_LPC, {CYC_MEMRD, 32'h0000_1234}, 1'h1);
    rd(START_HUBRD, {4'h0, 28'h000_0012, 4'h0}, 1'h1);
    wr(32'h0000_0099, 8'hC3);
    strap_select_i <= 4'h1;
    rd(START_LPC, {CYC_MEMRD, 32'h0040_0055}, 1'h1);
    rd(START_LPC, {CYC_MEMRD, 32'h0000_0055}, 1'h0);
    wb(1'h0, REG_STATUS, 32'h0, q);
    chk(q[8:5], 32'h1);
    strap_select_i <= 4'h0;
    pin_reset(1'h0);
    pin_reset(1'h1);
    interface_select_i <= 1'h1;
    lreset_n_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    lreset_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk(mux_mode_o, 32'h1);
    host_i.put(1'h0, 4'h5);
    host_i.put(1'h1, 4'h5);
    repeat (16) @(posedge clk_i);
    chk({arr_addr_o, arr_wdata_o}, {19'h0_0C30, 8'h05});
    chk(rd_cnt, 32'h6);
    chk(wr_cnt, 32'h2);
    end_of_test;
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
endmodule
